// ### verilog/spifc_top.sv
// Purpose: spi master/slave controller with byte fifos
// Assumes: serial mode 0, sck below core clock / 8 as slave
// Notes: one level interrupt, registers on a plain port
//
// Overview of operation
// - interrupt after 1, 2, 3 or 4 bytes, set by threshold code 00 to 11
// - flush bit empties and restarts both fifos, dropping their bytes
// - master sck divider: code 000 by 4, 001 by 6, 010 by 8
// - bit order bit 1 shifts msb first, 0 shifts lsb first
// - done flag set when the byte count reaches the threshold, cleared by writing 0 or disabling
// - byte arriving with receive fifo full sets overrun flag and interrupt
// - receive empty status reads 1 when receive fifo holds nothing
// - transmit full status reads 1 when transmit fifo has no room
// - transmit empty status reads 1 when transmit fifo holds nothing
// - data register read pops receive fifo, write pushes transmit fifo
`timescale 1ns/1ps
`default_nettype none
module spifc_top #(
  parameter int DEPTH = spifc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CE,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // serial clock pin
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_N,
  // select pin, active low
  input wire logic SSN_IN,
  output logic SSN_OUT,
  output logic SSN_OE_N,
  // data pins
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE_N,
  // interrupt
  output logic IRQ
);
  ////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] spi_config;
  logic [3:0] flags;
  logic [1:0] ctrl;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;

  // serial engine state
  spifc_pkg::spifc_state_type state;
  logic [7:0] half_cnt;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic sck_q;
  logic ssn_q;

  // pin synchronisers, order {sdi, ssn, sck}
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync_prev;
  wire [2:0] pins_in = {SDI, SSN_IN, SCK_IN};

  spifc_fifo_if #(.WIDTH(8)) tx_if ();
  spifc_fifo_if #(.WIDTH(8)) rx_if ();

  spifc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(CE),
    .port(tx_if.store)
  );

  spifc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(CE),
    .port(rx_if.store)
  );

  ////////////////////////////////////////////////////////////////
  // configuration decode
  wire enabled = ctrl[spifc_pkg::CTRL_EN];
  wire master = enabled & ctrl[spifc_pkg::CTRL_MASTER];
  wire slave = enabled & ~ctrl[spifc_pkg::CTRL_MASTER];
  wire msb_first = spi_config[spifc_pkg::CFG_DIR];
  wire flush = spi_config[spifc_pkg::CFG_FLUSH];
  wire [2:0] rate_sel = spi_config[spifc_pkg::CFG_RATE_LSB +: 3];
  wire [1:0] thr = spi_config[spifc_pkg::CFG_THR_LSB +: 2];
  wire [7:0] half_div = spifc_pkg::HALF_TABLE[{rate_sel, 3'h0} +: 8];

  // register port decode
  wire sel_config = (REG_ADDR == spifc_pkg::ADDR_CONFIG);
  wire sel_status = (REG_ADDR == spifc_pkg::ADDR_STATUS);
  wire sel_data = (REG_ADDR == spifc_pkg::ADDR_DATA);
  wire sel_ctrl = (REG_ADDR == spifc_pkg::ADDR_CTRL);
  wire sel_irq_stat = (REG_ADDR == spifc_pkg::ADDR_IRQ_STAT);
  wire sel_irq_clr = (REG_ADDR == spifc_pkg::ADDR_IRQ_CLR);
  wire sel_irq_en = (REG_ADDR == spifc_pkg::ADDR_IRQ_EN);
  wire wr_config = REG_WR & sel_config;
  wire wr_status = REG_WR & sel_status;
  wire wr_data = REG_WR & sel_data;
  wire wr_ctrl = REG_WR & sel_ctrl;
  wire wr_irq_clr = REG_WR & sel_irq_clr;
  wire wr_irq_en = REG_WR & sel_irq_en;
  wire rd_data = REG_RD & sel_data;

  ////////////////////////////////////////////////////////////////
  // synchronised pin view and edges
  wire sck_s = sync2[0];
  wire ssn_s = sync2[1];
  wire sdi_s = sync2[2];
  wire sck_rise = sck_s & ~sync_prev[0];
  wire sck_fall = ~sck_s & sync_prev[0];
  wire ssn_fall = ~ssn_s & sync_prev[1];
  // slave relies on sck slow enough to survive the synchroniser
  wire s_sample = slave & ~ssn_s & sck_rise;
  wire s_shift = slave & ~ssn_s & sck_fall;
  wire s_load = slave & ssn_fall;

  // master timing
  wire half_done = (state == spifc_pkg::RUN) && (half_cnt == half_div - 8'h01);
  wire m_sample = master & half_done & sck_q; // late read hides the two-cycle sdi synchroniser
  wire m_shift = master & half_done & sck_q;
  wire m_start = master & (state == spifc_pkg::IDLE) & ~tx_if.empty & ~flush;
  wire byte_edge = (bit_cnt == 3'h0);
  wire m_stop = m_shift & (bit_cnt == spifc_pkg::LAST_BIT) & tx_if.empty;

  // shared sample and shift events
  wire sample = m_sample | s_sample;
  wire shift = m_shift | s_shift;
  wire last_bit = sample & (bit_cnt == spifc_pkg::LAST_BIT);
  wire load = m_start | (m_shift & last_bit & ~tx_if.empty) | s_load | (s_shift & byte_edge);
  wire underrun = load & tx_if.empty & slave;
  wire [7:0] rx_byte = msb_first ? {rx_shift[6:0], sdi_s} : {sdi_s, rx_shift[7:1]};
  wire [7:0] tx_next = msb_first ? {tx_shift[6:0], 1'b0} : {1'b0, tx_shift[7:1]};
  wire tx_bit = msb_first ? tx_shift[7] : tx_shift[0];

  // events
  wire ev_done = last_bit & (byte_cnt == thr);
  wire ev_rx_overrun_flag = last_bit & rx_if.full;
  wire ev_tx_overflow_flag = wr_data & tx_if.full;
  wire [3:0] events = {ev_done, ev_rx_overrun_flag, ev_tx_overflow_flag, underrun};

  ////////////////////////////////////////////////////////////////
  // fifo hookup
  assign tx_if.push = wr_data;
  assign tx_if.push_data = REG_WDATA;
  assign tx_if.pop = load & ~flush;
  assign tx_if.flush = flush;
  assign rx_if.push = last_bit;
  assign rx_if.push_data = rx_byte;
  assign rx_if.pop = rd_data;
  assign rx_if.flush = flush;

  // status and read mux
  wire [7:0] status_rd = {flags, rx_if.full, rx_if.empty, tx_if.full, tx_if.empty};
  wire [7:0] data_rd = rx_if.empty ? 8'h00 : rx_if.pop_data;
  wire [7:0] read_mux = sel_config ? spi_config :
                        sel_status ? status_rd :
                        sel_data ? data_rd :
                        sel_ctrl ? {6'h00, ctrl} :
                        sel_irq_stat ? {4'h0, irq_status} :
                        sel_irq_en ? {4'h0, irq_enable} : 8'h00;

  // status write: a 0 clears a flag, a 1 leaves it; set wins
  wire [3:0] flag_keep = wr_status ? REG_WDATA[7:4] : 4'hF;
  wire [3:0] next_flags = enabled ? ((flags & flag_keep) | events) : spifc_pkg::FLAGS_RESET;
  wire [3:0] next_irq = (irq_status & ~(wr_irq_clr ? REG_WDATA[3:0] : 4'h0)) | events;

  // pins
  assign SCK_OUT = sck_q;
  assign SCK_OE_N = ~master;
  assign SSN_OUT = ssn_q;
  assign SSN_OE_N = ~master;
  assign SDO = tx_bit;
  assign SDO_OE_N = ~(master | (slave & ~ssn_s));
  assign IRQ = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////
  // synchronisers, one per pin
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          sync1[g] <= spifc_pkg::SYNC_RESET[g];
          sync2[g] <= spifc_pkg::SYNC_RESET[g];
          sync_prev[g] <= spifc_pkg::SYNC_RESET[g];
        end else if (CE) begin
          sync1[g] <= pins_in[g];
          sync2[g] <= sync1[g];
          sync_prev[g] <= sync2[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      spi_config <= spifc_pkg::CONFIG_RESET;
      ctrl <= spifc_pkg::CTRL_RESET;
      irq_enable <= spifc_pkg::IRQ_EN_RESET;
    end else if (CE) begin
      if (wr_config) spi_config <= REG_WDATA;
      if (wr_ctrl) ctrl <= REG_WDATA[1:0];
      if (wr_irq_en) irq_enable <= REG_WDATA[3:0];
    end
  end

  // flags and sticky interrupt status
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      flags <= spifc_pkg::FLAGS_RESET;
      irq_status <= spifc_pkg::FLAGS_RESET;
    end else if (CE) begin
      flags <= next_flags;
      irq_status <= next_irq;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (CE) begin
      REG_RDATA <= REG_RD ? read_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // master clock generator and frame
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= spifc_pkg::IDLE;
      half_cnt <= 8'h00;
      sck_q <= 1'b0;
      ssn_q <= 1'b1;
    end else if (CE) begin
      if (!master || flush) begin
        state <= spifc_pkg::IDLE;
        half_cnt <= 8'h00;
        sck_q <= 1'b0;
        ssn_q <= 1'b1;
      end else begin
        case (state)
          spifc_pkg::IDLE: begin
            if (m_start) begin
              state <= spifc_pkg::RUN;
              ssn_q <= 1'b0;
              half_cnt <= 8'h00;
            end
          end
          spifc_pkg::RUN: begin
            if (half_done) begin
              half_cnt <= 8'h00;
              sck_q <= ~sck_q;
            end else begin
              half_cnt <= half_cnt + 8'h01;
            end
            if (m_stop) begin
              state <= spifc_pkg::IDLE;
              ssn_q <= 1'b1;
            end
          end
          default: begin
            state <= spifc_pkg::IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // shifter, shared by both roles
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (CE) begin
      if (!enabled || flush || (slave && ssn_s)) begin
        bit_cnt <= 3'h0;
      end else begin
        if (sample) begin
          rx_shift <= rx_byte;
          bit_cnt <= bit_cnt + 3'h1;
        end
        // an empty fifo as slave sends zeros
        if (load) begin
          tx_shift <= tx_if.empty ? 8'h00 : tx_if.pop_data;
        end else if (shift) begin
          tx_shift <= tx_next;
        end
      end
    end
  end

  // completed bytes toward the interrupt threshold
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      byte_cnt <= 2'h0;
    end else if (CE) begin
      if (!enabled || flush) begin
        byte_cnt <= 2'h0;
      end else if (last_bit) begin
        byte_cnt <= (byte_cnt == thr) ? 2'h0 : byte_cnt + 2'h1;
      end
    end
  end
endmodule // spifc_top
`default_nettype wire

// ### common/spifc_pkg.sv
// Purpose: shared constants of the spi fifo controller
// Assumes: byte-wide register port, mode 0 serial timing
// Notes: offsets are register addresses on the plain port
package spifc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CONFIG = 8'hA1;
  localparam logic [7:0] ADDR_STATUS = 8'hA3;
  localparam logic [7:0] ADDR_DATA = 8'hA4;
  localparam logic [7:0] ADDR_CTRL = 8'hA5;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hA6;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'hA7;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
  // values after reset
  localparam logic [7:0] CONFIG_RESET = 8'h20;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam logic [2:0] SYNC_RESET = 3'h2;
  // spi_config fields
  localparam int CFG_DIR = 0;
  localparam int CFG_RATE_LSB = 1;
  localparam int CFG_FLUSH = 5;
  localparam int CFG_THR_LSB = 6;
  // spi_status flag fields, also irq bit order shifted down by 4
  localparam int ST_DONE = 7;
  localparam int ST_RX_OVERRUN_FLAG = 6;
  localparam int ST_TX_OVERFLOW_FLAG = 5;
  localparam int ST_TX_UNDERRUN_FLAG = 4;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  // half periods of the serial clock, in core cycles, code 7 first
  localparam logic [63:0] HALF_TABLE = {8'h80, 8'h20, 8'h10, 8'h0C, 8'h08, 8'h04, 8'h03, 8'h02};
  // counts
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // master engine states
  typedef enum logic {IDLE, RUN} spifc_state_type;
endpackage

// ### common/spifc_fifo_if.sv
// Purpose: carrier between the controller and one byte fifo
// Assumes: single clock, fill and drain from the same block
// Notes: pop_data shows the head entry while not empty
`timescale 1ns/1ps
`default_nettype none
interface spifc_fifo_if #(parameter int WIDTH = 8);
  logic push;
  logic [WIDTH-1:0] push_data;
  logic pop;
  logic [WIDTH-1:0] pop_data;
  logic full;
  logic empty;
  logic flush;
  modport store (input push, input push_data, input pop, input flush,
                 output pop_data, output full, output empty);
  modport user (output push, output push_data, output pop, output flush,
                input pop_data, input full, input empty);
endinterface
`default_nettype wire

// ### verilog/spifc_fifo.sv
// Purpose: small synchronous byte fifo
// Assumes: DEPTH of 2 or more
// Notes: push when full and pop when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module spifc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // storage side
  spifc_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire do_push = port.push & ~port.full;
  wire do_pop = port.pop & ~port.empty;
  wire [AW-1:0] wr_inc = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] rd_inc = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
  wire [AW:0] next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};

  assign port.full = (count == FULL_COUNT);
  assign port.empty = (count == '0);
  assign port.pop_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////
  // data array needs no reset: count guards every read
  always_ff @(posedge clk) begin
    if (ce && do_push && !port.flush) begin
      mem[wr_ptr] <= port.push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (port.flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
      end else begin
        if (do_push) wr_ptr <= wr_inc;
        if (do_pop) rd_ptr <= rd_inc;
        count <= next_count;
      end
    end
  end
endmodule // spifc_fifo
`default_nettype wire

// ### tb/spifc_properties.sv
// Purpose: port checker of the spi fifo controller
// Assumes: master role, half period of 2 or more cycles
// Notes: bound to the top module from the testbench file
`timescale 1ns/1ps
`default_nettype none
module spifc_properties (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // serial and interrupt
  input wire logic SCK_OUT,
  input wire logic SSN_OUT,
  input wire logic SDO,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic [8:0] hi_cnt;
  // slowest divider is 256, so one high phase never passes 128
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST)
      hi_cnt <= 9'h000;
    else
      hi_cnt <= SCK_OUT ? hi_cnt + 9'h001 : 9'h000;
  end
  ////////////////////////////////////////////////////////////
  property p_rdata_idle; !$past(REG_RD) |-> REG_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_unmapped; REG_RD && REG_ADDR == 8'hA2 |=> REG_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_sane;
    REG_RD && REG_ADDR == spifc_pkg::ADDR_STATUS |=> !(REG_RDATA[3] && REG_RDATA[2]) && !(REG_RDATA[1] && REG_RDATA[0]);
  endproperty
  a_status_sane: assert property (p_status_sane) else $error("fifo full and empty together");
  property p_idle_sck; SSN_OUT |-> !SCK_OUT; endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("sck moves outside frame");
  property p_high_min; $rose(SCK_OUT) |=> SCK_OUT; endproperty
  a_high_min: assert property (p_high_min) else $error("sck high too short");
  property p_low_min; $fell(SCK_OUT) && !SSN_OUT |=> !SCK_OUT; endproperty
  a_low_min: assert property (p_low_min) else $error("sck low too short");
  property p_lead; $fell(SSN_OUT) |-> !SCK_OUT ##1 !SCK_OUT; endproperty
  a_lead: assert property (p_lead) else $error("sck rises too soon after select");
  property p_sdo_hold; SCK_OUT && $past(SCK_OUT) |-> $stable(SDO); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("data changes while sck high");
  property p_high_max; hi_cnt <= 9'h080; endproperty
  a_high_max: assert property (p_high_max) else $error("sck high too long");
  property p_irq_mask;
    REG_WR && REG_ADDR == spifc_pkg::ADDR_IRQ_EN && REG_WDATA == 8'h00 |=> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq stays with all masked");
  c_frame: cover property ($fell(SSN_OUT));
  c_irq: cover property ($rose(IRQ));
  c_slow: cover property (hi_cnt == 9'h080);
endmodule // spifc_properties
`default_nettype wire

// ### tb/spifc_slave_model.sv
// Purpose: echo slave on the serial side
// Assumes: mode 0, select active low
// Notes: captured shows the bits in arrival order
`timescale 1ns/1ps
`default_nettype none
module spifc_slave_model (
  // pins from the master
  input wire logic sck,
  input wire logic ssn_n,
  input wire logic mosi,
  // data back and capture
  output logic miso,
  output logic [7:0] captured
);
  logic last;
  initial begin
    last = 1'b0;
    captured = 8'h00;
  end
  // first bit of a byte ends in bit 7
  always @(posedge sck) begin
    if (!ssn_n)
      captured <= {captured[6:0], mosi};
  end
  always @(mosi or ssn_n) begin
    if (!ssn_n)
      last = mosi;
  end
  // released line shows the inverse so stale data never reads back
  assign miso = ssn_n ? ~last : mosi;
endmodule // spifc_slave_model
`default_nettype wire

// ### tb/testbench.sv
// Purpose: register level tests of the spi fifo controller
// Assumes: echo slave in master role, bench drives the pins in slave role
// Notes: echo slave loops data back
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, nrst, reg_wr, reg_rd, sdi, sck_out, ssn_out, sdo, irq;
  logic ext_sck, ext_ssn_n, ext_mosi, slv_miso, sck_oe_n, ssn_oe_n, sdo_oe_n;
  logic [15:0] got16;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, captured, rd_val;
  int fail_count, comparisons, cyc, t0;
  localparam logic [8:0] DIV_TABLE [0:7] = '{9'h004, 9'h006, 9'h008, 9'h010, 9'h018, 9'h020, 9'h040, 9'h100};
  spifc_top i_dut (.CORE_CLK(core_clk), .NRST(nrst), .CE(1'b1), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SCK_IN(ext_sck), .SCK_OUT(sck_out),
    .SCK_OE_N(sck_oe_n), .SSN_IN(ext_ssn_n), .SSN_OUT(ssn_out), .SSN_OE_N(ssn_oe_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE_N(sdo_oe_n), .IRQ(irq));
  spifc_slave_model i_slave (.sck(sck_out), .ssn_n(ssn_out), .mosi(sdo), .miso(slv_miso), .captured(captured));
  // the bench owns the data line only while it selects the block as a slave
  assign sdi = ext_ssn_n ? slv_miso : ext_mosi;
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ceiling well above the roughly 4500 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(name, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic ichk(input logic exp);
    @(negedge core_clk);
    chk("irq", {15'h0000, exp}, {15'h0000, irq});
  endtask
  task automatic oechk(input logic [2:0] exp);
    @(negedge core_clk);
    chk("output enables", {13'h0000, exp}, {13'h0000, sck_oe_n, ssn_oe_n, sdo_oe_n});
  endtask
  // slave role frame; eight-cycle half periods keep sck below core clock / 8
  task automatic ext_frame(input logic [15:0] d, output logic [15:0] got);
    @(posedge core_clk);
    ext_ssn_n <= 1'b0;
    for (int b = 15; b >= 0; b--) begin
      ext_mosi <= d[b];
      repeat (7) @(posedge core_clk);
      @(negedge core_clk);
      got[b] = sdo;
      @(posedge core_clk);
      ext_sck <= 1'b1;
      repeat (8) @(posedge core_clk);
      ext_sck <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    ext_ssn_n <= 1'b1;
  endtask
  task automatic frame_end();
    wait (ssn_out === 1'b0);
    wait (ssn_out === 1'b1);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rise();
    @(negedge core_clk);
    while (sck_out !== 1'b0) @(negedge core_clk);
    while (sck_out !== 1'b1) @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fail_count = 0;
    comparisons = 0;
    ext_sck = 1'b0;
    ext_ssn_n = 1'b1;
    ext_mosi = 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(spifc_pkg::ADDR_CONFIG, spifc_pkg::CONFIG_RESET, "config");
    rchk(spifc_pkg::ADDR_STATUS, 8'h05, "status");
    rchk(spifc_pkg::ADDR_IRQ_EN, 8'h00, "irq_enable");
    rchk(8'hA2, 8'h00, "unmapped");
    ichk(1'b0);
    $display("test reset done");
    wr(spifc_pkg::ADDR_IRQ_EN, 8'h0F);
    wr(spifc_pkg::ADDR_CTRL, 8'h03);
    oechk(3'h0);
    for (int i = 0; i < 2; i++) begin
      wr(spifc_pkg::ADDR_CONFIG, i ? 8'h07 : 8'h06);
      wr(spifc_pkg::ADDR_DATA, 8'h1E);
      frame_end();
      chk("captured", {8'h00, i ? 8'h1E : 8'h78}, {8'h00, captured});
      rchk(spifc_pkg::ADDR_STATUS, 8'h81, "status done");
      ichk(1'b1);
      rchk(spifc_pkg::ADDR_DATA, 8'h1E, "rx byte");
      wr(spifc_pkg::ADDR_STATUS, 8'h0F);
      rchk(spifc_pkg::ADDR_STATUS, 8'h05, "status cleared");
      wr(spifc_pkg::ADDR_IRQ_CLR, 8'h0F);
      ichk(1'b0);
    end
    $display("test bit order done");
    wr(spifc_pkg::ADDR_CONFIG, 8'hC7);
    for (int i = 0; i < 5; i++) wr(spifc_pkg::ADDR_DATA, 8'(8'h10 + i));
    rchk(spifc_pkg::ADDR_STATUS, 8'h06, "status tx full");
    wr(spifc_pkg::ADDR_DATA, 8'h77);
    frame_end();
    rchk(spifc_pkg::ADDR_STATUS, 8'hE9, "status errors");
    ichk(1'b1);
    rchk(spifc_pkg::ADDR_DATA, 8'h10, "rx head");
    wr(spifc_pkg::ADDR_CONFIG, 8'hE7);
    rchk(spifc_pkg::ADDR_STATUS, 8'hE5, "status flushed");
    wr(spifc_pkg::ADDR_CONFIG, 8'hC7);
    wr(spifc_pkg::ADDR_CTRL, 8'h00);
    rchk(spifc_pkg::ADDR_STATUS, 8'h05, "status disabled");
    wr(spifc_pkg::ADDR_IRQ_EN, 8'h00);
    ichk(1'b0);
    wr(spifc_pkg::ADDR_IRQ_CLR, 8'h0F);
    $display("test threshold and errors done");
    wr(spifc_pkg::ADDR_CTRL, 8'h03);
    // each echoed byte is read back, so the fastest rate proves the sdi timing too
    for (int c = 0; c < 8; c++) begin
      wr(spifc_pkg::ADDR_CONFIG, {4'h0, 3'(c), 1'b1});
      wr(spifc_pkg::ADDR_DATA, 8'h5A);
      rise();
      t0 = cyc;
      rise();
      chk("sck period", {7'h00, DIV_TABLE[c]}, 16'(cyc - t0));
      frame_end();
      rchk(spifc_pkg::ADDR_DATA, 8'h5A, "rate rx");
    end
    $display("test rates done");
    wr(spifc_pkg::ADDR_CTRL, 8'h01);
    wr(spifc_pkg::ADDR_CONFIG, 8'h01);
    wr(spifc_pkg::ADDR_STATUS, 8'h0F);
    wr(spifc_pkg::ADDR_DATA, 8'hA5);
    oechk(3'h7);
    ext_frame(16'h3CC3, got16);
    chk("slave sent", 16'hA500, got16);
    rchk(spifc_pkg::ADDR_STATUS, 8'h91, "status underrun");
    rchk(spifc_pkg::ADDR_DATA, 8'h3C, "slave rx first");
    rchk(spifc_pkg::ADDR_DATA, 8'hC3, "slave rx second");
    $display("test slave done");
    stop_test();
  end
endmodule // testbench
bind spifc_top spifc_properties i_props (.CORE_CLK(CORE_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCK_OUT(SCK_OUT),
  .SSN_OUT(SSN_OUT), .SDO(SDO), .IRQ(IRQ));
`default_nettype wire
